// ===== rsbc_checker.sv
// Purpose: receive character status encoder with self-test compare
// Assumes: decoder flags arrive on this clock; lock comes from the PLL
// Notes:   Avalon-MM slave, answer one cycle after the request
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module rsbc_checker
  import rsbc_pkg::*;
#(
  parameter int EXC_W = 8,
  parameter int LEN_W = 9
) (
  // Clock, reset, enable
  input  wire logic        ref_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        ce_in,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Decoded character stream
  input  wire logic        char_valid_in,
  input  wire logic [7:0]  char_in,
  input  wire logic        char_is_cmd_in,
  input  wire logic        framing_match_in,
  input  wire logic        special_in,
  input  wire logic        codeword_err_in,
  input  wire logic        disparity_err_in,
  input  wire logic        buf_fault_in,
  input  wire logic        pll_locked_in,
  // Output register
  output logic             out_valid_out,
  output logic      [7:0]  rx_data_out,
  output logic      [2:0]  rx_char_status_out,
  output logic             irq_out
);
  logic rst_meta, rst_n;
  logic lock_meta, lock_sync;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else if (ce_in) begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // PLL lock is asynchronous to this clock
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end else if (ce_in) begin
      lock_meta <= pll_locked_in;
      lock_sync <= lock_meta;
    end
  end

  function automatic logic [EXC_W-1:0] sat_step(
    input logic [EXC_W-1:0] v, input logic up);
    logic [EXC_W-1:0] r;
    r = v;
    if (up && v != {EXC_W{1'b1}})
      r = v + EXC_W'(1);
    else if (!up && v != '0)
      r = v - EXC_W'(1);
    return r;
  endfunction : sat_step

  // Register and bus state
  logic [2:0]      ctrl, next_ctrl;
  logic [EV_W-1:0] events, next_events;
  logic [EV_W-1:0] mask, next_mask;
  logic [31:0]     next_readdata;
  logic            next_waitrequest, next_irq;
  logic            rd_ack, wr_ack;
  logic [EV_W-1:0] ev_set;

  // Checker and output state
  rsbc_state_t      state, next_state;
  logic [EXC_W-1:0] excess, next_excess;
  logic [3:0]       hold, next_hold;
  logic             lock_prev, next_lock_prev;
  logic             next_out_valid;
  logic [7:0]       next_rx_data;
  logic [2:0]       next_status;
  logic             gen_restart, gen_step;
  logic [7:0]       exp_char;
  logic             exp_cmd, exp_last;

  rsbc_pattern_gen #(
    .LEN_W (LEN_W),
    .LEN   (SEQ_LEN)
  ) u_gen (
    .clk_in       (ref_clk_in),
    .rst_n_in     (rst_n),
    .ce_in        (ce_in),
    .restart_in   (gen_restart),
    .step_in      (gen_step),
    .exp_char_out (exp_char),
    .exp_cmd_out  (exp_cmd),
    .exp_last_out (exp_last)
  );

  wire bist_en  = ctrl[CTRL_BIST_EN];
  wire type_b   = ctrl[CTRL_TYPE_SEL];
  wire dec_en   = ctrl[CTRL_DEC_SEL];
  wire lock_bad = !lock_sync;
  wire in_hold  = (hold != 4'h0);
  wire is_first = char_valid_in && !char_is_cmd_in
                  && (char_in == FIRST_CHAR);
  wire matched  = (char_in == exp_char) && (char_is_cmd_in == exp_cmd);

  always_comb begin
    next_state     = state;
    next_excess    = excess;
    next_hold      = hold;
    next_lock_prev = lock_sync;
    next_out_valid = char_valid_in;
    next_rx_data   = char_valid_in ? char_in : rx_data_out;
    next_status    = rx_char_status_out;
    gen_restart    = 1'b0;
    gen_step       = 1'b0;
    ev_set         = '0;

    ev_set[EV_LOCK_LOSS] = lock_prev && lock_bad;
    ev_set[EV_BUF_FAULT] = buf_fault_in;

    // Re-centring counts characters, not clocks
    if (buf_fault_in)
      next_hold = 4'(RECENTRE_CHARS);
    else if (in_hold && char_valid_in)
      next_hold = hold - 4'h1;

    if (!bist_en) begin
      next_state  = RSBC_START;
      next_excess = '0;
    end else if (lock_bad || buf_fault_in || in_hold) begin
      next_state  = RSBC_START;
      next_excess = '0;
    end else if (char_valid_in) begin
      case (state)
        RSBC_START: begin
          next_state = RSBC_AWAIT;
        end
        RSBC_AWAIT: begin
          if (is_first) begin
            next_state  = RSBC_COMPARE;
            next_excess = '0;
            gen_restart = 1'b1;
          end
        end
        RSBC_COMPARE: begin
          gen_step    = 1'b1;
          next_excess = sat_step(excess, !matched);
          if (!matched)
            ev_set[EV_BIST_ERR] = 1'b1;
          if (exp_last) begin
            next_state = RSBC_AWAIT;
            ev_set[EV_LAST_BAD] = !matched;
          end else if (!matched
                       && excess >= EXC_W'(EXCESS_LIMIT)) begin
            next_state = RSBC_AWAIT;
          end
        end
        default: next_state = RSBC_START;
      endcase
    end

    if (char_valid_in) begin
      ev_set[EV_CODEWORD]  = codeword_err_in && dec_en && !bist_en;
      ev_set[EV_DISPARITY] = disparity_err_in && dec_en && !bist_en;
    end

    if (bist_en) begin
      if (lock_bad || buf_fault_in || in_hold || state == RSBC_START)
        next_status = ST_B_START;
      else if (char_valid_in) begin
        case (state)
          RSBC_AWAIT:
            next_status = is_first ? ST_B_DATA : ST_B_WAIT;
          RSBC_COMPARE:
            if (exp_last)
              next_status = matched ? ST_B_GOOD : ST_B_BAD;
            else if (!matched)
              next_status = ST_B_ERROR;
            else
              next_status = char_is_cmd_in ? ST_B_CMD : ST_B_DATA;
          default: next_status = ST_B_START;
        endcase
      end
    end else if (!dec_en) begin
      // Bypassed decoder: only the framing flag is meaningful
      if (char_valid_in)
        next_status = {2'b00, framing_match_in};
    end else if (lock_bad) begin
      next_status = ST_LOCK;
    end else if (buf_fault_in) begin
      next_status = ST_UNDERRUN;
    end else if (char_valid_in) begin
      // Priority chain: codeword, framing, disparity, special, then normal
      if (codeword_err_in)
        next_status = ST_CODEWORD;
      else if (framing_match_in && !type_b)
        next_status = ST_FRAMING;
      else if (disparity_err_in)
        next_status = ST_DISPARITY;
      else if (special_in || framing_match_in)
        next_status = ST_SPECIAL;
      else
        next_status = ST_NORMAL;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state              <= RSBC_START;
      excess             <= '0;
      hold               <= 4'h0;
      lock_prev          <= 1'b0;
      out_valid_out      <= 1'b0;
      rx_data_out        <= 8'h00;
      rx_char_status_out <= ST_B_START;
    end else if (ce_in) begin
      state              <= next_state;
      excess             <= next_excess;
      hold               <= next_hold;
      lock_prev          <= next_lock_prev;
      out_valid_out      <= next_out_valid;
      rx_data_out        <= next_rx_data;
      rx_char_status_out <= next_status;
    end
  end

  // Bus: waitrequest drops one cycle after a request appears
  assign rd_ack = avs_read_in && !avs_waitrequest_out;
  assign wr_ack = avs_write_in && !avs_waitrequest_out;

  always_comb begin
    next_ctrl        = ctrl;
    next_mask        = mask;
    next_events      = events;
    next_readdata    = avs_readdata_out;
    next_waitrequest = !((avs_read_in || avs_write_in)
                         && avs_waitrequest_out);
    if (wr_ack) begin
      case (avs_address_in)
        REG_CTRL: next_ctrl = avs_writedata_in[2:0];
        REG_MASK: next_mask = avs_writedata_in[EV_W-1:0];
        default: ;
      endcase
    end
    if (avs_read_in && avs_waitrequest_out) begin
      case (avs_address_in)
        REG_CTRL:   next_readdata = {29'h0, ctrl};
        REG_EVENTS: next_readdata = {{(32-EV_W){1'b0}}, events};
        REG_MASK:   next_readdata = {{(32-EV_W){1'b0}}, mask};
        REG_STATE:  next_readdata = {{(32-EXC_W-8){1'b0}}, excess,
                                     lock_sync, rx_char_status_out,
                                     2'b00, state};
        default:    next_readdata = 32'h0;
      endcase
    end
    // Read clears, but a new event in the same cycle survives
    if (rd_ack && avs_address_in == REG_EVENTS)
      next_events = '0;
    next_events = next_events | ev_set;
    next_irq    = |(next_events & mask);
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl                <= CTRL_RESET;
      mask                <= '0;
      events              <= '0;
      avs_readdata_out    <= 32'h0;
      avs_waitrequest_out <= 1'b1;
      irq_out             <= 1'b0;
    end else if (ce_in) begin
      ctrl                <= next_ctrl;
      mask                <= next_mask;
      events              <= next_events;
      avs_readdata_out    <= next_readdata;
      avs_waitrequest_out <= next_waitrequest;
      irq_out             <= next_irq;
    end
  end
endmodule : rsbc_checker

// ===== rsbc_checker_chk.sv
// Purpose: port checks of the receive status encoder
// Assumes: control writes seen on the bus mirror the control register
// Notes:   data checks wait for a settled lock; recovery is not judged
`timescale 1ns/1ps
module rsbc_checker_chk
  import rsbc_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk_in,
  input wire logic        arst_n_in,
  // Bus
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic        avs_waitrequest_out,
  // Character path
  input wire logic        char_valid_in,
  input wire logic [7:0]  char_in,
  input wire logic        char_is_cmd_in,
  input wire logic        framing_match_in,
  input wire logic        special_in,
  input wire logic        codeword_err_in,
  input wire logic        disparity_err_in,
  input wire logic        buf_fault_in,
  input wire logic        pll_locked_in,
  input wire logic [2:0]  rx_char_status_out
);
  logic [2:0] ctrl;
  logic [2:0] next_ctrl;
  logic [3:0] lk_cnt;
  logic [3:0] next_lk_cnt;
  logic       ok;
  logic       dm;
  logic       bm;
  always_comb begin
    next_ctrl = ctrl;
    if (avs_write_in && !avs_waitrequest_out && avs_address_in == REG_CTRL)
      next_ctrl = avs_writedata_in[2:0];
    next_lk_cnt = pll_locked_in ? lk_cnt + {3'h0, lk_cnt != 4'hf} : 4'h0;
  end
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl   <= CTRL_RESET;
      lk_cnt <= 4'h0;
    end else begin
      ctrl   <= next_ctrl;
      lk_cnt <= next_lk_cnt;
    end
  end
  // Lock passes a synchroniser, so give it time to settle
  assign bm = ctrl[CTRL_BIST_EN] && lk_cnt > 4'h8;
  assign ok = char_valid_in && !buf_fault_in && lk_cnt > 4'h8;
  assign dm = ok && ctrl[CTRL_DEC_SEL] && !ctrl[CTRL_BIST_EN];
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  sequence s_lost;
    (!pll_locked_in && (ctrl[CTRL_DEC_SEL] || ctrl[CTRL_BIST_EN])) [*6];
  endsequence
  sequence s_held;
    (rx_char_status_out == ST_B_START) [*7];
  endsequence
  property p_lock;
    s_lost |-> rx_char_status_out == ST_LOCK;
  endproperty
  a_lock: assert property (p_lock) else $error("no 101 when unlocked");
  property p_cw;
    dm && codeword_err_in |=> rx_char_status_out == ST_CODEWORD;
  endproperty
  a_cw: assert property (p_cw) else $error("codeword code wrong");
  property p_frm;
    dm && !ctrl[CTRL_TYPE_SEL] && framing_match_in && !codeword_err_in
      |=> rx_char_status_out == ST_FRAMING;
  endproperty
  a_frm: assert property (p_frm) else $error("framing code wrong");
  property p_disp;
    dm && disparity_err_in && !codeword_err_in && !framing_match_in
      |=> rx_char_status_out == ST_DISPARITY;
  endproperty
  a_disp: assert property (p_disp) else $error("disparity code wrong");
  property p_spec;
    dm && special_in && !codeword_err_in && !disparity_err_in
      && !framing_match_in |=> rx_char_status_out == ST_SPECIAL;
  endproperty
  a_spec: assert property (p_spec) else $error("special code wrong");
  property p_raw;
    ok && !ctrl[CTRL_DEC_SEL] && !ctrl[CTRL_BIST_EN]
      |=> rx_char_status_out == {2'b00, $past(framing_match_in)};
  endproperty
  a_raw: assert property (p_raw) else $error("bypass status wrong");
  property p_go;
    ok && bm && rx_char_status_out == ST_B_WAIT && char_in == FIRST_CHAR
      && !char_is_cmd_in |=> rx_char_status_out == ST_B_DATA;
  endproperty
  a_go: assert property (p_go) else $error("start char not taken");
  property p_buf;
    bm && buf_fault_in |-> ##2 s_held;
  endproperty
  a_buf: assert property (p_buf) else $error("start not held");
endmodule : rsbc_checker_chk

bind rsbc_checker rsbc_checker_chk u_chk (
  .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
  .avs_address_in(avs_address_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in),
  .avs_waitrequest_out(avs_waitrequest_out),
  .char_valid_in(char_valid_in), .char_in(char_in),
  .char_is_cmd_in(char_is_cmd_in), .framing_match_in(framing_match_in),
  .special_in(special_in), .codeword_err_in(codeword_err_in),
  .disparity_err_in(disparity_err_in), .buf_fault_in(buf_fault_in),
  .pll_locked_in(pll_locked_in), .rx_char_status_out(rx_char_status_out)
);

// ===== rsbc_host_model.sv
// Purpose: host logic that loads the receiver's output register
// Assumes: one load per output strobe
// Notes:   keeps the last status only; the bench reads it after a load
`timescale 1ns/1ps
module rsbc_host_model
  import rsbc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Output register
  input  wire logic       valid_in,
  input  wire logic [2:0] status_in,
  // Loaded status
  output logic      [2:0] status_out
);
  logic [2:0] next_status;
  always_comb begin
    next_status = status_out;
    if (valid_in)
      next_status = status_in;
  end
  // Same clock setup as the sending end, never a separate one
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      status_out <= 3'h0;
    else
      status_out <= next_status;
  end
endmodule : rsbc_host_model

// ===== rsbc_pkg.sv
// Purpose: constants and the expected-pattern generator of the receive
//          status encoder and self-test checker
// Assumes: one character per enabled clock, flagged by a valid strobe
// Notes:   generator steps only on characters the checker compares
// Notes on behaviour
// - Self-test mode reports compare state on status
// - Lock loss forces checker to start state
// - Errors over matches by 17: await D0.0
// - Buffer fault holds start until re-centred
// - Code 101 means started, lock or buffer fault
// - Code 110 means compare mismatch
// - Code 111 means awaiting start-of-pattern character
// - Non-framing special character gives 001, priority 7
// - First type framing character gives 011
// - Undecodable character gives 100, priority 4
// - Disparity error gives 110
// - Lock loss gives 101, overrides all
// - Smallest priority number wins among conditions
// - Status type chosen by dedicated select
// - Status meaningful only with decoder enabled
package rsbc_pkg;
  // Register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_EVENTS = 4'h4;
  localparam logic [3:0] REG_MASK   = 4'h8;
  localparam logic [3:0] REG_STATE  = 4'hc;
  // Control fields
  localparam int CTRL_BIST_EN  = 0;
  localparam int CTRL_TYPE_SEL = 1;
  localparam int CTRL_DEC_SEL  = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  // Event bits
  localparam int EV_W         = 6;
  localparam int EV_LOCK_LOSS = 0;
  localparam int EV_BUF_FAULT = 1;
  localparam int EV_CODEWORD  = 2;
  localparam int EV_DISPARITY = 3;
  localparam int EV_BIST_ERR  = 4;
  localparam int EV_LAST_BAD  = 5;
  // Status codes
  localparam logic [2:0] ST_NORMAL    = 3'h0;
  localparam logic [2:0] ST_SPECIAL   = 3'h1;
  localparam logic [2:0] ST_UNDERRUN  = 3'h2;
  localparam logic [2:0] ST_FRAMING   = 3'h3;
  localparam logic [2:0] ST_CODEWORD  = 3'h4;
  localparam logic [2:0] ST_LOCK      = 3'h5;
  localparam logic [2:0] ST_DISPARITY = 3'h6;
  localparam logic [2:0] ST_B_DATA    = 3'h0;
  localparam logic [2:0] ST_B_CMD     = 3'h1;
  localparam logic [2:0] ST_B_GOOD    = 3'h2;
  localparam logic [2:0] ST_B_BAD     = 3'h4;
  localparam logic [2:0] ST_B_START   = 3'h5;
  localparam logic [2:0] ST_B_ERROR   = 3'h6;
  localparam logic [2:0] ST_B_WAIT    = 3'h7;
  // Pattern constants
  localparam logic [7:0] FIRST_CHAR   = 8'h00;
  localparam int         EXCESS_LIMIT = 16;
  localparam int         RECENTRE_CHARS = 9;
  localparam int         SEQ_LEN      = 511;
  localparam logic [7:0] LFSR_SEED    = 8'h01;
  localparam logic [7:0] LFSR_TAPS    = 8'hb8;

  typedef enum logic [1:0] {
    RSBC_START, RSBC_AWAIT, RSBC_COMPARE
  } rsbc_state_t;
endpackage : rsbc_pkg

`timescale 1ns/1ps
module rsbc_pattern_gen
  import rsbc_pkg::*;
#(
  parameter int LEN_W = 9,
  parameter int LEN   = SEQ_LEN
) (
  // Clocking
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  // Control
  input  wire logic       restart_in,
  input  wire logic       step_in,
  // Expected character
  output logic [7:0]      exp_char_out,
  output logic            exp_cmd_out,
  output logic            exp_last_out
);
  logic [7:0]       lfsr;
  logic [7:0]       next_lfsr;
  logic [LEN_W-1:0] pos;
  logic [LEN_W-1:0] next_pos;

  always_comb begin
    next_lfsr = lfsr;
    next_pos  = pos;
    if (restart_in) begin
      next_lfsr = LFSR_SEED;
      next_pos  = LEN_W'(1);
    end else if (step_in) begin
      next_lfsr = lfsr[0] ? ((lfsr >> 1) ^ LFSR_TAPS) : (lfsr >> 1);
      next_pos  = pos + LEN_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lfsr <= LFSR_SEED;
      pos  <= '0;
    end else if (ce_in) begin
      lfsr <= next_lfsr;
      pos  <= next_pos;
    end
  end

  // Command positions are a fixed subset so both kinds get exercised
  assign exp_char_out = lfsr;
  assign exp_cmd_out  = &lfsr[2:0];
  assign exp_last_out = (pos == LEN_W'(LEN - 1));
endmodule : rsbc_pattern_gen

// ===== rx_status_bist_checker_tb_top.sv
// Purpose: self-checking bench for the receive status encoder
// Assumes: clock enable held high, a character every four cycles
// Notes:   pattern expectations come from the seed and taps constants
`timescale 1ns/1ps
module rx_status_bist_checker_tb_top;
  import rsbc_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic        cv = 1'b0;
  logic [7:0]  ch = 8'h00;
  logic        cmd = 1'b0;
  logic [3:0]  fl = 4'h0;
  logic        bf = 1'b0;
  logic        lock = 1'b1;
  logic [31:0] rdat;
  logic        wreq;
  logic        ov;
  logic [2:0]  st;
  logic [7:0]  dat;
  logic        irq;
  logic [2:0]  h_st;
  logic [31:0] v;
  logic [7:0]  lf;
  logic [2:0]  e;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;

  // Flags: framing, special, codeword, disparity
  rsbc_checker dut (
    .ref_clk_in(clk), .arst_n_in(arst_n), .ce_in(1'b1),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .char_valid_in(cv), .char_in(ch),
    .char_is_cmd_in(cmd), .framing_match_in(fl[3]), .special_in(fl[2]),
    .codeword_err_in(fl[1]), .disparity_err_in(fl[0]),
    .buf_fault_in(bf), .pll_locked_in(lock), .out_valid_out(ov),
    .rx_data_out(dat), .rx_char_status_out(st), .irq_out(irq));
  rsbc_host_model host (
    .clk_in(clk), .rst_n_in(arst_n), .valid_in(ov), .status_in(st),
    .status_out(h_st));

  always #12.5 clk = ~clk;

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp_w

  // No limit of its own: a dead slave ends in the bench timeout
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    v = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic put(input logic [7:0] c, input logic k, input logic [3:0] f);
    @(posedge clk);
    cv <= 1'b1;
    ch <= c;
    cmd <= k;
    fl <= f;
    @(posedge clk);
    cv <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : put

  task automatic pc(input logic [7:0] c, input logic k, input logic [3:0] f,
                    input logic [2:0] x);
    put(c, k, f);
    cmp_w({29'h0, h_st}, {29'h0, x});
  endtask : pc

  task automatic drop(input logic [2:0] x);
    @(posedge clk);
    lock <= 1'b0;
    repeat (7) @(posedge clk);
    cmp_w({29'h0, st}, {29'h0, x});
    lock <= 1'b1;
    repeat (12) @(posedge clk);
  endtask : drop

  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, REG_CTRL, 32'h0);
    cmp_w(v, 32'h4);
    bus(1'b0, REG_MASK, 32'h0);
    cmp_w(v, 32'h0);
    bus(1'b1, REG_EVENTS, 32'hff);
    bus(1'b0, 4'h2, 32'h0);
    cmp_w(v, 32'h0);
    bus(1'b0, REG_EVENTS, 32'h0);
    cmp_w(v, 32'h0);
    $display("test registers done");
    pc(8'h41, 1'b0, 4'h0, ST_NORMAL);
    pc(8'hbc, 1'b1, 4'h4, ST_SPECIAL);
    cmp_w({24'h0, dat}, 32'hbc);
    pc(8'hbc, 1'b1, 4'hc, ST_FRAMING);
    pc(8'h41, 1'b0, 4'ha, ST_CODEWORD);
    pc(8'h41, 1'b0, 4'h1, ST_DISPARITY);
    pc(8'hbc, 1'b1, 4'h5, ST_DISPARITY);
    bus(1'b1, REG_MASK, 32'h4);
    repeat (2) @(posedge clk);
    cmp_w({31'h0, irq}, 32'h1);
    bus(1'b0, REG_EVENTS, 32'h0);
    cmp_w(v, 32'hc);
    repeat (2) @(posedge clk);
    cmp_w({31'h0, irq}, 32'h0);
    pc(8'h41, 1'b0, 4'h2, ST_CODEWORD);
    cmp_w({31'h0, irq}, 32'h1);
    bus(1'b1, REG_MASK, 32'h0);
    repeat (2) @(posedge clk);
    cmp_w({31'h0, irq}, 32'h0);
    $display("test data status done");
    bus(1'b1, REG_CTRL, 32'h6);
    pc(8'hbc, 1'b1, 4'h8, ST_SPECIAL);
    bus(1'b1, REG_CTRL, 32'h0);
    pc(8'hbc, 1'b1, 4'h8, 3'h1);
    pc(8'h41, 1'b0, 4'h0, 3'h0);
    bus(1'b1, REG_CTRL, 32'h4);
    bus(1'b0, REG_EVENTS, 32'h0);
    cmp_w(v, 32'h4);
    drop(ST_LOCK);
    bus(1'b0, REG_EVENTS, 32'h0);
    cmp_w(v, 32'h1);
    $display("test modes and lock done");
    bus(1'b1, REG_CTRL, 32'h5);
    pc(8'h55, 1'b0, 4'h0, ST_B_START);
    pc(8'h55, 1'b0, 4'h0, ST_B_WAIT);
    pc(FIRST_CHAR, 1'b0, 4'h0, ST_B_DATA);
    lf = LFSR_SEED;
    for (int i = 1; i < SEQ_LEN; i++) begin
      e = &lf[2:0] ? ST_B_CMD : ST_B_DATA;
      if (i == SEQ_LEN - 1)
        e = ST_B_GOOD;
      pc(lf, &lf[2:0], 4'h0, e);
      lf = (lf >> 1) ^ (lf[0] ? LFSR_TAPS : 8'h00);
    end
    pc(8'h33, 1'b0, 4'h0, ST_B_WAIT);
    $display("test pattern done");
    pc(FIRST_CHAR, 1'b0, 4'h0, ST_B_DATA);
    repeat (EXCESS_LIMIT) pc(8'h00, 1'b1, 4'h0, ST_B_ERROR);
    pc(8'h00, 1'b1, 4'h0, ST_B_ERROR);
    pc(8'h00, 1'b1, 4'h0, ST_B_WAIT);
    @(posedge clk);
    bf <= 1'b1;
    @(posedge clk);
    bf <= 1'b0;
    repeat (RECENTRE_CHARS) pc(8'h55, 1'b0, 4'h0, ST_B_START);
    pc(8'h55, 1'b0, 4'h0, ST_B_START);
    pc(8'h55, 1'b0, 4'h0, ST_B_WAIT);
    pc(FIRST_CHAR, 1'b0, 4'h0, ST_B_DATA);
    bus(1'b0, REG_STATE, 32'h0);
    cmp_w(v, 32'h82);
    drop(ST_B_START);
    bus(1'b0, REG_STATE, 32'h0);
    cmp_w(v, 32'hd0);
    pc(8'h55, 1'b0, 4'h0, ST_B_START);
    $display("test faults done");
    wrap_up();
  end
endmodule : rx_status_bist_checker_tb_top
